// file: verilog/tfi_host_interface.sv
// Host bus and formatter data path with request, lost data and event latches.
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// RULE_01: Six address bits compared to base, two one-of-eight decoders make strobes.
// RULE_02: Base port is fixed by wiring, not configurable.
// RULE_03: Host read drives selected status or address register onto input bus.
// RULE_04: DMA fetch captures input bus byte into output register at strobe end.
// RULE_05: Optional partition mode gates middle address byte under address gate.
// RULE_06: Address and internal control load true; external and command load inverted.
// RULE_07: Input data register drives output bus only while DMA write enable is high.
// RULE_08: Input data loads at DMA cycle end, or on read strobe with no DMA.
// RULE_09: Optional partition mode gates upper address byte onto output bus.
// RULE_10: Read mode captures formatter data at read strobe trailing edge.
// RULE_11: Read strobe end raises request unless file mark or erase commanded.
// RULE_12: Bus sync clears request once DMA cycle is in progress.
// RULE_13: Write mode raises request at end of write data initiate.
// RULE_14: Formatter acks each byte; ack end raises next request.
// RULE_15: Transfer done blocks requests and asserts final byte flag; the code does both in write mode only.
// RULE_16: With enable set, interrupt only on tape deceleration after motion.
// RULE_17: Reading formatter status clears pending interrupt.
// RULE_18: Read mode sets lost data on strobe while request still set.
// RULE_19: Write mode sets lost data on ack while DMA cycle in progress.
// RULE_20: Any formatter command clears lost data.
// RULE_21: End of tape, hard error, file mark latched; new command clears them.
// RULE_22: Internal control bit three drives formatter enable and gates loads.
// RULE_23: Final byte flag marks next strobed byte as last of record.
// RULE_24: Interrupt request is held level until clearing status read.
module tfi_host_interface
  import tfi_pkg::*;
(
  // Clock and reset.
  input wire logic i_sys_clk,
  input wire logic i_rst,
  // Programmed I/O from the host.
  input wire logic [7:0] i_port_addr,
  input wire logic i_io_wr,
  input wire logic i_io_rd,
  input wire logic [7:0] i_host_write_bus,
  output logic [7:0] o_host_read_bus,
  output logic o_host_read_oe,
  // DMA sequencer signals.
  input wire logic i_dma_in_progress,
  input wire logic i_dma_data_in_strobe,
  input wire logic i_bus_sync,
  input wire logic i_dma_cycle_end,
  input wire logic i_dma_out_drive_enable,
  input wire logic i_address_byte_gate,
  input wire logic i_partition_enable,
  input wire logic i_transfer_done_flag,
  input wire logic [7:0] i_addr_lo,
  input wire logic [7:0] i_addr_mid,
  input wire logic [7:0] i_addr_hi,
  input wire logic [7:0] i_host_write_bus_in,
  output logic [7:0] o_host_write_bus,
  output logic o_host_write_bus_oe,
  output logic o_dma_service_request,
  // DMA address register loads.
  output logic [7:0] o_addr_lo_load,
  output logic [7:0] o_addr_mid_load,
  output logic o_addr_lo_we,
  output logic o_addr_mid_we,
  // Formatter pins.
  input wire logic [7:0] i_read_data,
  input wire logic i_read_char_strobe_in,
  input wire logic i_write_char_ack_strobe,
  input wire logic i_write_data_initiate,
  input wire logic i_data_busy,
  input wire logic i_end_of_tape,
  input wire logic i_hard_error,
  input wire logic i_file_mark,
  input wire logic [7:0] i_transport_status,
  output logic [7:0] o_write_data,
  output logic [7:0] o_ext_control,
  output logic [7:0] o_fmt_command,
  output logic o_fmt_command_strobe,
  output logic o_formatter_enable_out,
  output logic o_final_byte_flag,
  output logic o_irq
);
  // ==========================================================================
  // State
  // ==========================================================================
  typedef struct packed {
    logic [1:0] read_char_strobe_in_sync;
    logic [1:0] write_char_ack_strobe_sync;
    logic [1:0] go_sync;
    logic [1:0] busy_sync;
    logic [1:0] eot_sync;
    logic [1:0] herr_sync;
    logic [1:0] fmk_sync;
    logic [7:0] rdat_s1;
    logic [7:0] rdat_s2;
    logic read_char_strobe_in_d;
    logic write_char_ack_strobe_d;
    logic go_d;
    logic busy_d;
    logic motion;
    logic pdbin_d;
    logic [7:0] in_data;
    logic [7:0] out_data;
    logic [7:0] icr;
    logic [7:0] ecr;
    logic [7:0] cmd;
    logic cmd_strobe;
    logic dma_service_request;
    logic lost;
    logic eot;
    logic herr;
    logic fmk;
    logic irq;
    logic [7:0] rd_bus;
    logic rd_oe;
  } tfi_state_t;

  tfi_state_t st;
  tfi_state_t next_st;
  logic [7:0] load_a;
  logic [7:0] load_b;
  logic [7:0] read_a;
  logic read_char_strobe_in_fall;
  logic write_char_ack_strobe_fall;
  logic go_fall;
  logic busy_fall;
  logic run;
  logic new_cmd;
  logic fs_read;
  logic [7:0] fmt_status;

  // ==========================================================================
  // Port decoding
  // ==========================================================================
  // Base compare and the load and read strobe banks. [RULE_01] [RULE_02]
  tfi_port_decode u_decode (
    .i_port_addr(i_port_addr),
    .i_io_wr(i_io_wr),
    .i_io_rd(i_io_rd),
    .o_load_a(load_a),
    .o_load_b(load_b),
    .o_read_a(read_a)
  );

  // Edge detects read only the second synchroniser stage.
  always_comb begin
    read_char_strobe_in_fall = st.read_char_strobe_in_d & ~st.read_char_strobe_in_sync[1];
    write_char_ack_strobe_fall = st.write_char_ack_strobe_d & ~st.write_char_ack_strobe_sync[1];
    go_fall = st.go_d & ~st.go_sync[1];
    busy_fall = st.busy_d & ~st.busy_sync[1];
    run = st.icr[TFI_ICR_RUN_BIT];
    new_cmd = load_b[TFI_LD_CMD] & run;
    fs_read = read_a[TFI_RD_FMT_STAT];
    fmt_status = TFI_BYTE_RST;
    fmt_status[TFI_FS_LOST_BIT] = st.lost;
    fmt_status[TFI_FS_EOT_BIT] = st.eot;
    fmt_status[TFI_FS_HERR_BIT] = st.herr;
    fmt_status[TFI_FS_FMK_BIT] = st.fmk;
    fmt_status[TFI_FS_IRQ_BIT] = st.irq;
  end

  // ==========================================================================
  // Next-state logic
  // ==========================================================================
  always_comb begin
    next_st = st;
    // Two-flop synchronisers for every formatter input except transport status.
    next_st.read_char_strobe_in_sync = {st.read_char_strobe_in_sync[0], i_read_char_strobe_in};
    next_st.write_char_ack_strobe_sync = {st.write_char_ack_strobe_sync[0], i_write_char_ack_strobe};
    next_st.go_sync = {st.go_sync[0], i_write_data_initiate};
    next_st.busy_sync = {st.busy_sync[0], i_data_busy};
    next_st.eot_sync = {st.eot_sync[0], i_end_of_tape};
    next_st.herr_sync = {st.herr_sync[0], i_hard_error};
    next_st.fmk_sync = {st.fmk_sync[0], i_file_mark};
    next_st.rdat_s1 = i_read_data;
    next_st.rdat_s2 = st.rdat_s1;
    next_st.read_char_strobe_in_d = st.read_char_strobe_in_sync[1];
    next_st.write_char_ack_strobe_d = st.write_char_ack_strobe_sync[1];
    next_st.go_d = st.go_sync[1];
    next_st.busy_d = st.busy_sync[1];
    next_st.pdbin_d = i_dma_data_in_strobe;
    next_st.cmd_strobe = 1'b0;

    // Host register loads: true data to control, inverted to ext and command. [RULE_06]
    if (load_a[TFI_LD_ICR]) begin
      next_st.icr = i_host_write_bus;
    end
    if (load_a[TFI_LD_ECR] && run) begin // [RULE_22]
      next_st.ecr = ~i_host_write_bus; // [RULE_06]
    end
    if (new_cmd) begin
      next_st.cmd = ~i_host_write_bus; // [RULE_06]
      next_st.cmd_strobe = 1'b1;
    end

    // DMA fetch byte captured at data-in strobe trailing edge. [RULE_04]
    if (st.pdbin_d && !i_dma_data_in_strobe) begin
      next_st.out_data = i_host_write_bus_in;
    end

    // Input data register load sources. [RULE_08]
    if (i_dma_cycle_end) begin
      next_st.in_data = st.rdat_s2;
    end else if (read_char_strobe_in_fall && !i_dma_in_progress && !st.ecr[TFI_ECR_WRSEL_BIT]) begin
      next_st.in_data = st.rdat_s2; // [RULE_10]
    end

    // Data request: bus sync clears; set terms win over the clear. [RULE_12]
    if (i_dma_in_progress && i_bus_sync) begin
      next_st.dma_service_request = 1'b0;
    end
    if (!st.ecr[TFI_ECR_WRSEL_BIT]) begin
      if (read_char_strobe_in_fall && !st.ecr[TFI_ECR_FMARK_BIT] && !st.ecr[TFI_ECR_ERASE_BIT]) begin
        next_st.dma_service_request = 1'b1; // [RULE_11]
      end
    end else if (!i_transfer_done_flag && (go_fall || write_char_ack_strobe_fall)) begin
      next_st.dma_service_request = 1'b1; // [RULE_13] [RULE_14] [RULE_15]
    end

    // Lost data: cleared by a command, set wins in the same cycle. [RULE_20]
    if (new_cmd) begin
      next_st.lost = 1'b0;
      next_st.eot = 1'b0; // [RULE_21]
      next_st.herr = 1'b0;
      next_st.fmk = 1'b0;
      next_st.motion = 1'b1;
    end
    if (!st.ecr[TFI_ECR_WRSEL_BIT] && read_char_strobe_in_fall && st.dma_service_request) begin
      next_st.lost = 1'b1; // [RULE_18]
    end
    if (st.ecr[TFI_ECR_WRSEL_BIT] && write_char_ack_strobe_fall && i_dma_in_progress) begin
      next_st.lost = 1'b1; // [RULE_19]
    end

    // Formatter event latches. [RULE_21]
    if (st.eot_sync[1]) begin
      next_st.eot = 1'b1;
    end
    if (st.herr_sync[1]) begin
      next_st.herr = 1'b1;
    end
    if (st.fmk_sync[1]) begin
      next_st.fmk = 1'b1;
    end

    // Interrupt held until status read; deceleration set wins. [RULE_17] [RULE_24]
    if (fs_read) begin
      next_st.irq = 1'b0;
    end
    if (busy_fall && st.motion) begin
      next_st.motion = 1'b0;
      if (st.icr[TFI_ICR_IRQEN_BIT]) begin
        next_st.irq = 1'b1; // [RULE_16]
      end
    end

    // Host read path, including optional middle address byte. [RULE_03] [RULE_05]
    next_st.rd_oe = |read_a || (i_partition_enable && i_address_byte_gate);
    if (i_partition_enable && i_address_byte_gate) begin
      next_st.rd_bus = i_addr_mid;
    end else if (read_a[TFI_RD_XPORT_STAT]) begin
      next_st.rd_bus = i_transport_status;
    end else if (fs_read) begin
      next_st.rd_bus = fmt_status;
    end else if (read_a[TFI_RD_ADDR_LO]) begin
      next_st.rd_bus = i_addr_lo;
    end else if (read_a[TFI_RD_ADDR_MID]) begin
      next_st.rd_bus = i_addr_mid;
    end else begin
      next_st.rd_bus = TFI_BYTE_RST;
    end
  end

  // ==========================================================================
  // State register
  // ==========================================================================
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // ==========================================================================
  // Outputs
  // ==========================================================================
  // Address register loads pass through non-inverted.
  always_comb begin
    o_addr_lo_load = i_host_write_bus; // [RULE_06]
    o_addr_mid_load = i_host_write_bus;
    o_addr_lo_we = load_a[TFI_LD_ADDR_LO];
    o_addr_mid_we = load_a[TFI_LD_ADDR_MID];
  end

  // Output bus carries input data under write enable, or the upper address byte.
  always_comb begin
    if (i_partition_enable && i_address_byte_gate) begin
      o_host_write_bus = i_addr_hi; // [RULE_09]
    end else begin
      o_host_write_bus = st.in_data;
    end
    o_host_write_bus_oe = i_dma_out_drive_enable
      | (i_partition_enable & i_address_byte_gate); // [RULE_07]
  end

  // Registered outputs, except the final byte flag, which gates the live transfer done input.
  assign o_host_read_bus = st.rd_bus;
  assign o_host_read_oe = st.rd_oe;
  assign o_write_data = st.out_data;
  assign o_ext_control = st.ecr;
  assign o_fmt_command = st.cmd;
  assign o_fmt_command_strobe = st.cmd_strobe;
  assign o_dma_service_request = st.dma_service_request;
  assign o_formatter_enable_out = run; // [RULE_22]
  assign o_final_byte_flag = i_transfer_done_flag & st.ecr[TFI_ECR_WRSEL_BIT]; // [RULE_15] [RULE_23]
  assign o_irq = st.irq;
endmodule
`default_nettype wire

// file: inc/tfi_pkg.sv
// Constants shared by the tape formatter host interface.
package tfi_pkg;
  // ==========================================================================
  // Port decoding
  // ==========================================================================
  localparam logic [5:0] TFI_BASE_PORT = 6'h28; // Upper six bits of port 8'hA0.
  localparam int TFI_BASE_LSB = 2;
  localparam int TFI_SEL_W = 2;
  // Load strobe slots (port low bits).
  localparam logic [2:0] TFI_LD_ADDR_LO = 3'h0;
  localparam logic [2:0] TFI_LD_ADDR_MID = 3'h1;
  localparam logic [2:0] TFI_LD_ICR = 3'h2;
  localparam logic [2:0] TFI_LD_ECR = 3'h3;
  // Read strobe slots (port low bits).
  localparam logic [2:0] TFI_RD_XPORT_STAT = 3'h0;
  localparam logic [2:0] TFI_RD_FMT_STAT = 3'h1;
  localparam logic [2:0] TFI_RD_ADDR_LO = 3'h2;
  localparam logic [2:0] TFI_RD_ADDR_MID = 3'h3;
  // Second decoder bank for formatter command load.
  localparam logic [2:0] TFI_LD_CMD = 3'h0;
  // ==========================================================================
  // Field positions
  // ==========================================================================
  localparam int TFI_ICR_RUN_BIT = 3;
  localparam int TFI_ICR_IRQEN_BIT = 0;
  localparam int TFI_ECR_WRSEL_BIT = 0;
  localparam int TFI_ECR_FMARK_BIT = 1;
  localparam int TFI_ECR_ERASE_BIT = 2;
  localparam int TFI_FS_LOST_BIT = 0;
  localparam int TFI_FS_EOT_BIT = 1;
  localparam int TFI_FS_HERR_BIT = 2;
  localparam int TFI_FS_FMK_BIT = 3;
  localparam int TFI_FS_IRQ_BIT = 4;
  // ==========================================================================
  // Reset values
  // ==========================================================================
  localparam logic [7:0] TFI_BYTE_RST = 8'h00;
endpackage

// file: verilog/tfi_port_decode.sv
// I/O port decoder: base compare and two one-of-eight strobe decoders.
`timescale 1ns/1ps
`default_nettype none
module tfi_port_decode
  import tfi_pkg::*;
(
  // Host address and cycle qualifiers.
  input wire logic [7:0] i_port_addr,
  input wire logic i_io_wr,
  input wire logic i_io_rd,
  // Decoded strobes.
  output logic [7:0] o_load_a,
  output logic [7:0] o_load_b,
  output logic [7:0] o_read_a
);
  logic hit;

  // Expand a three-bit slot into a one-hot strobe set.
  function automatic logic [7:0] one_of_eight(input logic [2:0] sel, input logic en);
    one_of_eight = en ? (8'h01 << sel) : 8'h00;
  endfunction

  // Six address bits compared against the wired base; two decoders follow. [RULE_01] [RULE_02]
  // The command bank shares the middle address port, so that write also issues a command.
  always_comb begin
    hit = (i_port_addr[7:TFI_BASE_LSB] == TFI_BASE_PORT);
    o_load_a = one_of_eight({1'b0, i_port_addr[1:0]}, hit & i_io_wr);
    o_load_b = one_of_eight(TFI_LD_CMD,
      hit & i_io_wr & (i_port_addr[1:0] == TFI_LD_ADDR_MID[1:0]));
    o_read_a = one_of_eight({1'b0, i_port_addr[1:0]}, hit & i_io_rd);
  end
endmodule
`default_nettype wire

// file: verif/tfi_host_interface_sva.sv
// Concurrent checks on the tape formatter host interface ports.
`timescale 1ns/1ps
`default_nettype none
module tfi_host_interface_sva (
  // Clock, reset and host cycle.
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic [7:0] i_port_addr,
  input wire logic i_io_wr,
  input wire logic i_io_rd,
  input wire logic [7:0] i_host_write_bus,
  input wire logic [7:0] i_transport_status,
  // Sequencer levels.
  input wire logic i_dma_in_progress,
  input wire logic i_bus_sync,
  input wire logic i_dma_out_drive_enable,
  input wire logic i_address_byte_gate,
  input wire logic i_transfer_done_flag,
  // Watched outputs.
  input wire logic [7:0] o_host_read_bus,
  input wire logic o_host_write_bus_oe,
  input wire logic o_dma_service_request,
  input wire logic [7:0] o_addr_lo_load,
  input wire logic o_addr_lo_we,
  input wire logic [7:0] o_ext_control,
  input wire logic o_formatter_enable_out,
  input wire logic o_irq
);
  // ==========================================================================
  // Assertions
  // ==========================================================================
  // All checks sample on the rising clock and rest while reset is held.
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);
  chk_fen_from_icr: assert property (
    i_io_wr && i_port_addr == 8'hA2 |=> o_formatter_enable_out == $past(i_host_write_bus[3]))
    else $error("formatter enable does not follow control bit three");
  chk_addr_true_load: assert property (
    i_io_wr && i_port_addr == 8'hA0 |-> o_addr_lo_we && o_addr_lo_load == i_host_write_bus)
    else $error("address low load is not a true copy");
  chk_ecr_inverted: assert property (
    i_io_wr && i_port_addr == 8'hA3 && o_formatter_enable_out
      |=> o_ext_control == ~$past(i_host_write_bus))
    else $error("external control is not the inverted host byte");
  chk_ecr_refused: assert property (
    i_io_wr && i_port_addr == 8'hA3 && !o_formatter_enable_out |=> $stable(o_ext_control))
    else $error("external control loaded while run bit is low");
  chk_out_drive: assert property (
    i_dma_out_drive_enable || !i_address_byte_gate |-> o_host_write_bus_oe == i_dma_out_drive_enable)
    else $error("output bus drive does not follow the write enable");
  chk_status_read: assert property (
    i_io_rd && i_port_addr == 8'hA0 |=> o_host_read_bus == $past(i_transport_status))
    else $error("transport status not returned on read");
  chk_req_hold: assert property (
    o_dma_service_request && !(i_bus_sync && i_dma_in_progress) |=> o_dma_service_request)
    else $error("request dropped without bus sync");
  chk_req_clear: assert property (
    o_dma_service_request && i_bus_sync && i_dma_in_progress |=> !o_dma_service_request)
    else $error("request not cleared by bus sync");
  chk_done_blocks: assert property (
    $past(i_transfer_done_flag) && i_transfer_done_flag |-> !$rose(o_dma_service_request))
    else $error("request raised after transfer done");
  chk_irq_level: assert property (
    o_irq && !(i_io_rd && i_port_addr == 8'hA1) |=> o_irq)
    else $error("interrupt dropped before the status read");
  chk_irq_clear: assert property (
    i_io_rd && i_port_addr == 8'hA1 |=> !o_irq)
    else $error("interrupt not cleared by status read");
endmodule
bind tfi_host_interface tfi_host_interface_sva i_chk (.*);
`default_nettype wire

// file: verif/tfi_fmt_model.sv
// Behavioural tape formatter driving strobes, read data and busy.
`timescale 1ns/1ps
`default_nettype none
module tfi_fmt_model (
  // Clock that paces the pins.
  input wire logic i_sys_clk,
  // Formatter pins toward the interface.
  output logic [7:0] o_read_data,
  output logic o_busy,
  output logic [5:0] o_pulse
);
  // ==========================================================================
  // Pin drivers
  // ==========================================================================
  // Lines start quiet; strobes are active high pulses.
  initial begin
    o_read_data = 8'h00;
    o_busy = 1'b0;
    o_pulse = 6'h00;
  end
  // One strobe per byte, four clocks high and five low so each edge is resolved.
  task automatic pulse(input int k);
    @(negedge i_sys_clk);
    o_pulse[k] = 1'b1;
    repeat (4) @(negedge i_sys_clk);
    o_pulse[k] = 1'b0;
    repeat (5) @(negedge i_sys_clk);
  endtask
  // Data is held through the strobe, then turned over so stale bytes never match.
  task automatic send_byte(input logic [7:0] d);
    o_read_data = d;
    pulse(0);
    o_read_data = ~d;
  endtask
  // A tape motion: busy rises, the initiate pulses, busy drops as the tape slows.
  task automatic motion();
    o_busy = 1'b1;
    pulse(2);
    o_busy = 1'b0;
    repeat (6) @(negedge i_sys_clk);
  endtask
endmodule
`default_nettype wire

// file: verif/tb_top.sv
// Self-checking bench for the tape formatter host interface.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import tfi_pkg::*;
  // ==========================================================================
  // Signals
  // ==========================================================================
  logic i_sys_clk = '0, i_rst = '1, i_io_wr = '0, i_io_rd = '0, i_dma_in_progress = '0;
  logic i_dma_data_in_strobe = '0, i_bus_sync = '0, i_dma_cycle_end = '0, i_address_byte_gate = '0;
  logic i_dma_out_drive_enable = '0, i_partition_enable = '0, i_transfer_done_flag = '0;
  logic [7:0] i_port_addr = '0, i_host_write_bus = '0, i_addr_lo = '0, i_addr_mid = '0;
  logic [7:0] i_addr_hi = '0, i_host_write_bus_in = '0, i_transport_status = '0;
  wire logic [7:0] i_read_data;
  wire logic i_read_char_strobe_in, i_write_char_ack_strobe, i_write_data_initiate, i_data_busy;
  wire logic i_end_of_tape, i_hard_error, i_file_mark;
  logic [7:0] o_host_read_bus, o_host_write_bus, o_addr_lo_load, o_addr_mid_load, o_write_data;
  logic [7:0] o_ext_control, o_fmt_command, d, e, seen_ld;
  logic o_host_read_oe, o_host_write_bus_oe, o_dma_service_request, o_addr_lo_we, o_addr_mid_we;
  logic o_fmt_command_strobe, o_formatter_enable_out, o_final_byte_flag, o_irq, seen_we;
  int num_errors = 0, n_tests = 0, seed = 32'h69f1;
  tfi_host_interface i_tfi_host_interface (.*);
  tfi_fmt_model i_tfi_fmt_model (
    .i_sys_clk(i_sys_clk),
    .o_read_data(i_read_data),
    .o_busy(i_data_busy),
    .o_pulse({i_file_mark, i_hard_error, i_end_of_tape, i_write_data_initiate,
      i_write_char_ack_strobe, i_read_char_strobe_in})
  );
  // ==========================================================================
  // Helpers
  // ==========================================================================
  // Free-running 100 MHz clock.
  initial begin
    forever #5 i_sys_clk = ~i_sys_clk;
  end
  // Byte and bit comparisons.
  task automatic cmp(input string nm, input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic cmpb(input string nm, input logic got, input logic exp);
    cmp(nm, {7'h00, got}, {7'h00, exp});
  endtask
  // Host whose inversion sets write select and file mark in external control.
  function automatic logic [7:0] host_ecr(input logic wrsel, input logic fmark);
    return ~((8'h01 & {7'h00, wrsel}) << TFI_ECR_WRSEL_BIT | {7'h00, fmark} << TFI_ECR_FMARK_BIT);
  endfunction
  // Event latch bits gathered after k plus one events.
  function automatic logic [7:0] ev_exp(input int k);
    return (8'h01 << (k + 2)) - 8'h02;
  endfunction
  // One host port cycle; the address load strobe is sampled 1 ns into the cycle, before the rising edge.
  task automatic io(input logic wr, input logic [7:0] a, input logic [7:0] dat);
    @(negedge i_sys_clk);
    i_io_wr = wr;
    i_io_rd = !wr;
    i_port_addr = a;
    i_host_write_bus = dat;
    #1;
    seen_we = o_addr_lo_we;
    seen_ld = o_addr_lo_load;
    @(negedge i_sys_clk);
    i_io_wr = 0;
    i_io_rd = 0;
  endtask
  // Reset for four clocks.
  task automatic rst();
    i_rst = 1;
    repeat (4) @(negedge i_sys_clk);
    i_rst = 0;
  endtask
  // Bus sync while a cycle is in progress.
  task automatic sync();
    @(negedge i_sys_clk);
    i_bus_sync = 1;
    i_dma_in_progress = 1;
    @(negedge i_sys_clk);
    i_bus_sync = 0;
    i_dma_in_progress = 0;
  endtask
  // Verdict and end of run.
  task automatic conclude();
    $display("Checks %0d, mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // ==========================================================================
  // Scenarios
  // ==========================================================================
  // Watchdog for a hung handshake.
  initial begin
    #100000;
    num_errors++;
    conclude();
  end
  // Main sequence.
  initial begin
    rst();
    cmpb("request at reset", o_dma_service_request, 0);
    for (int k = 0; k < 4; k++) begin
      d = $random(seed);
      e = $random(seed);
      io(1, 8'hA2, {d[7:4], 1'b1, d[2:0]});
      cmpb("formatter enable", o_formatter_enable_out, 1);
      io(1, 8'hA0, d);
      cmp("addr lo load", seen_ld, d);
      cmpb("addr lo strobe", seen_we, 1);
      io(1, 8'hA3, e);
      cmp("ext control", o_ext_control, ~e);
      i_transport_status = d;
      i_addr_lo = e;
      io(0, 8'hA0, 8'h00);
      cmp("transport status", o_host_read_bus, d);
      io(0, 8'hA2, 8'h00);
      cmp("addr lo read", o_host_read_bus, e);
    end
    io(1, 8'hA2, 8'h00);
    io(1, 8'hA3, e);
    cmp("ext control refused", o_ext_control, ~e);
    // Read mode: capture, request, then a second byte while still pending.
    io(1, 8'hA2, 8'h08);
    io(1, 8'hA3, host_ecr(0, 0));
    d = $random(seed);
    i_tfi_fmt_model.send_byte(d);
    cmpb("read request", o_dma_service_request, 1);
    i_dma_out_drive_enable = 1;
    #1;
    cmp("read byte", o_host_write_bus, d);
    cmpb("out drive", o_host_write_bus_oe, 1);
    i_dma_out_drive_enable = 0;
    i_tfi_fmt_model.send_byte(~d);
    cmp("second byte", o_host_write_bus, ~d);
    io(0, 8'hA1, 8'h00);
    cmpb("lost in read", o_host_read_bus[TFI_FS_LOST_BIT], 1);
    cmpb("read drive", o_host_read_oe, 1);
    // The end of a transfer cycle reloads the input register from the read lines.
    i_dma_cycle_end = 1;
    @(negedge i_sys_clk);
    i_dma_cycle_end = 0;
    cmp("cycle end load", o_host_write_bus, d);
    sync();
    cmpb("request cleared", o_dma_service_request, 0);
    io(1, 8'hA3, host_ecr(0, 1));
    i_tfi_fmt_model.send_byte(d);
    cmpb("file mark blocks", o_dma_service_request, 0);
    // Partition option gates the address bytes onto both buses.
    i_partition_enable = 1;
    i_addr_hi = d;
    i_addr_mid = ~d;
    i_address_byte_gate = 1;
    @(negedge i_sys_clk);
    cmp("upper byte", o_host_write_bus, d);
    cmp("middle byte", o_host_read_bus, ~d);
    i_address_byte_gate = 0;
    // Write mode: prefetch, fetch, acknowledge, overrun and final byte.
    rst();
    io(1, 8'hA2, 8'h08);
    io(1, 8'hA3, host_ecr(1, 0));
    i_tfi_fmt_model.pulse(2);
    cmpb("prefetch request", o_dma_service_request, 1);
    sync();
    d = $random(seed);
    i_host_write_bus_in = d;
    i_dma_data_in_strobe = 1;
    repeat (2) @(negedge i_sys_clk);
    i_dma_data_in_strobe = 0;
    repeat (2) @(negedge i_sys_clk);
    cmp("fetched byte", o_write_data, d);
    i_tfi_fmt_model.pulse(1);
    cmpb("ack request", o_dma_service_request, 1);
    sync();
    i_dma_in_progress = 1;
    i_tfi_fmt_model.pulse(1);
    i_dma_in_progress = 0;
    io(0, 8'hA1, 8'h00);
    cmpb("lost in write", o_host_read_bus[TFI_FS_LOST_BIT], 1);
    io(1, 8'hA1, d);
    cmp("command byte", o_fmt_command, ~d);
    cmpb("command strobe", o_fmt_command_strobe, 1);
    io(0, 8'hA1, 8'h00);
    cmpb("lost cleared", o_host_read_bus[TFI_FS_LOST_BIT], 0);
    sync();
    i_transfer_done_flag = 1;
    i_tfi_fmt_model.pulse(1);
    cmpb("done blocks", o_dma_service_request, 0);
    cmpb("final byte", o_final_byte_flag, 1);
    i_transfer_done_flag = 0;
    // Interrupt on deceleration, masked and then enabled.
    io(1, 8'hA2, 8'h08);
    io(1, 8'hA1, 8'h00);
    i_tfi_fmt_model.motion();
    cmpb("irq masked", o_irq, 0);
    io(1, 8'hA2, 8'h09);
    io(1, 8'hA1, 8'h00);
    i_tfi_fmt_model.motion();
    cmpb("irq raised", o_irq, 1);
    repeat (3) @(negedge i_sys_clk);
    cmpb("irq held", o_irq, 1);
    io(0, 8'hA1, 8'h00);
    cmpb("irq status", o_host_read_bus[TFI_FS_IRQ_BIT], 1);
    cmpb("irq cleared", o_irq, 0);
    // End of tape, hard error and file mark latch one by one.
    rst();
    for (int k = 0; k < 3; k++) begin
      i_tfi_fmt_model.pulse(3 + k);
      io(0, 8'hA1, 8'h00);
      cmp("event latches", o_host_read_bus & 8'h0E, ev_exp(k));
    end
    // A new command clears the event latches and lost data.
    io(1, 8'hA2, 8'h08);
    io(1, 8'hA1, 8'h00);
    io(0, 8'hA1, 8'h00);
    cmp("events cleared", o_host_read_bus & 8'h0F, 8'h00);
    conclude();
  end
endmodule
`default_nettype wire
